/* File: rtl/ccrp_params.svh */
// Purpose: Constants of the codec register control port
// Assumes: Included by the package and the port module
// Notes: Register reset value is uniform across the map
`ifndef CCRP_PARAMS_SVH
`define CCRP_PARAMS_SVH
`define CCRP_NREGS 128
`define CCRP_REG_RST 8'h00
`define CCRP_I2C_ADDR 7'h18
`define CCRP_GC_ADDR 7'h00
`define CCRP_GC_REG 7'h22
`define CCRP_GC_BIT 5
`define CCRP_BYTE_BITS 4'h8
`define CCRP_ADDR_LAST 5'h06
`define CCRP_RW_LAST 5'h07
`define CCRP_CMD_BITS 5'h08
`define CCRP_DATA_LAST 5'h0f
`define CCRP_FRAME_BITS 5'h10
`define CCRP_RW_READ 1'b1
`endif

/* File: rtl/ccrp_pkg.sv */
// Purpose: Types shared by the codec register control port
// Assumes: Constants come from ccrp_params.svh
// Notes: None
`include "ccrp_params.svh"
package ccrp_pkg;
   typedef struct packed {
      logic [6:0] addr;
      logic [7:0] data;
   } ccrp_wr_s;
   typedef enum logic [8:0] {
      ST_IDLE      = 9'h001,
      ST_ADDR      = 9'h002,
      ST_ADDR_ACK  = 9'h004,
      ST_REG       = 9'h008,
      ST_REG_ACK   = 9'h010,
      ST_WDATA     = 9'h020,
      ST_WDATA_ACK = 9'h040,
      ST_RDATA     = 9'h080,
      ST_RDATA_ACK = 9'h100
   } ccrp_i2c_e;
endpackage

/* File: rtl/ccrp_ctrl_port.sv */
// Purpose: I2C or SPI slave giving a host access to 128 byte-wide codec registers
// Assumes: SPI sclk period of 30 ns or more; clk at 250 MHz
// Notes: The register array lives here and is mirrored out as a write strobe
// Function
// - I2C write without STOP stores each further byte at the next address.
// - I2C read continues with the next register while the master acknowledges.
// - SPI clock idles low between transfers.
// - Master and device both start driving data on the first clock edge.
// - A byte shifts out on slave-out while one shifts in.
// - First eight bits after select falls are the command; select may stay low.
// - Second eight bits are write data only for a write command.
// - Command holds address in bits 7..1, MSB first, direction in bit 0.
// - Direction bit is 0 for write, 1 for read.
// - Read data leaves on slave-out during the second eight clocks.
// - In SPI mode shared pins serve as frame select and serial input.
// - Protocol pin high selects SPI, low selects I2C.
// - I2C slave answers address 0011000, and the general call once it is enabled.
// - General call answered only once configuration bit 5 is set.
`timescale 1ns/100ps
`include "ccrp_params.svh"
module ccrp_ctrl_port
   import ccrp_pkg::*;
(
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic spiSelPin,
   input wire logic sclFsPin,
   input wire logic sdaMosiPin,
   input wire logic sclk,
   output logic sdaOut,
   output logic sdaOe,
   output logic misoOut,
   output logic misoOe,
   output ccrp_wr_s regWr,
   output logic regWrStb,
   output logic gcEnable
);
   // System domain state
   logic [7:0] regMem_ff [0:`CCRP_NREGS-1];
   logic selM_ff, selS_ff;
   logic sclM_ff, sclS_ff, sclP_ff;
   logic sdaM_ff, sdaS_ff, sdaP_ff;
   logic rqM_ff, rqS_ff, rqP_ff;
   logic wtM_ff, wtS_ff, wtP_ff;
   ccrp_i2c_e state_ff, nxt_state;
   logic [3:0] bitCnt_ff, nxt_bitCnt;
   logic [7:0] sh_ff, nxt_sh;
   logic [6:0] ptr_ff, nxt_ptr;
   logic rw_ff, nxt_rw;
   logic ackd_ff, nxt_ackd;
   logic sdaOe_ff, nxt_oe;
   logic sdaOut_ff;
   logic [7:0] rdByte_ff;
   ccrp_wr_s regWr_ff;
   logic regWrStb_ff;
   logic gcEnable_ff;
   logic i2cWr;

   // Link domain state
   logic [4:0] spiCnt_ff;
   logic [6:0] spiSh_ff;
   logic [6:0] spiAddr_ff;
   logic [7:0] spiData_ff;
   logic spiRw_ff;
   logic rdTgl_ff, wrTgl_ff;
   logic [7:0] misoSh_ff;
   logic misoOut_ff, misoOe_ff;

   // Decode
   wire spiMode = selS_ff;
   wire i2cOn = ~spiMode;
   wire sclRise = sclS_ff & ~sclP_ff;
   wire sclFall = ~sclS_ff & sclP_ff;
   // START and STOP are the only SDA moves allowed while SCL is high
   wire startCond = sclS_ff & sclP_ff & sdaP_ff & ~sdaS_ff;
   wire stopCond = sclS_ff & sclP_ff & ~sdaP_ff & sdaS_ff;
   wire byteDone = (bitCnt_ff == `CCRP_BYTE_BITS);
   wire ownHit = (sh_ff[7:1] == `CCRP_I2C_ADDR);
   wire gcHit = (sh_ff[7:1] == `CCRP_GC_ADDR) & gcEnable_ff & ~sh_ff[0];
   wire addrHit = ownHit | gcHit;
   wire [7:0] rdCur = regMem_ff[ptr_ff];
   // Pointer wraps from 127 back to 0
   wire [6:0] ptrInc = ptr_ff + 7'h01;
   wire [3:0] cntInc = bitCnt_ff + 4'h1;
   // Toggle handshakes: a change of level marks one event from the link side
   wire rdReq = rqS_ff ^ rqP_ff;
   wire spiWr = (wtS_ff ^ wtP_ff) & spiMode;
   wire memWe = i2cWr | spiWr;
   // Only one protocol is live at a time, so the two writers never meet
   wire ccrp_wr_s i2cWord = ccrp_wr_s'{addr: ptr_ff, data: sh_ff};
   wire ccrp_wr_s spiWord = ccrp_wr_s'{addr: spiAddr_ff, data: spiData_ff};
   wire ccrp_wr_s memWr = i2cWr ? i2cWord : spiWord;
   // Frame ends, or I2C is chosen, clear the link counter, shifters and MISO drive at once
   wire fsRst = sclFsPin | ~spiSelPin;
   wire cmdDone = (spiCnt_ff == `CCRP_CMD_BITS);
   wire spiFull = (spiCnt_ff == `CCRP_FRAME_BITS);
   wire [4:0] spiCntInc = spiCnt_ff + 5'h01;

   // Next bit to the top, zero fill behind it
   function automatic logic [7:0] shiftOut(input logic [7:0] v);
      return {v[6:0], 1'b0};
   endfunction

   // Synchronisers: first stage feeds only the second
   always_ff @(posedge clk) begin
      selM_ff <= spiSelPin;
      selS_ff <= selM_ff;
      sclM_ff <= sclFsPin;
      sclS_ff <= sclM_ff;
      sclP_ff <= sclS_ff;
      sdaM_ff <= sdaMosiPin;
      sdaS_ff <= sdaM_ff;
      sdaP_ff <= sdaS_ff;
      rqM_ff <= rdTgl_ff;
      rqS_ff <= rqM_ff;
      rqP_ff <= rqS_ff;
      wtM_ff <= wrTgl_ff;
      wtS_ff <= wtM_ff;
      wtP_ff <= wtS_ff;
   end

   // I2C slave sequencing
   always_comb begin
      nxt_state = state_ff;
      nxt_bitCnt = bitCnt_ff;
      nxt_sh = sh_ff;
      nxt_ptr = ptr_ff;
      nxt_rw = rw_ff;
      nxt_ackd = ackd_ff;
      nxt_oe = sdaOe_ff;
      i2cWr = 1'b0;
      // STOP, or a switch to SPI, abandons any transfer
      if (!i2cOn || stopCond) begin
         nxt_state = ST_IDLE;
         nxt_oe = 1'b0;
      end else if (startCond) begin
         nxt_state = ST_ADDR;
         nxt_bitCnt = 4'h0;
         nxt_oe = 1'b0;
      end else begin
         unique case (state_ff)
            ST_IDLE: begin
               nxt_oe = 1'b0;
            end
            ST_ADDR, ST_REG, ST_WDATA: begin
               if (sclRise && !byteDone) begin
                  nxt_sh = {sh_ff[6:0], sdaS_ff};
                  nxt_bitCnt = cntInc;
               end else if (sclFall && byteDone) begin
                  nxt_bitCnt = 4'h0;
                  if (state_ff == ST_ADDR) begin
                     if (addrHit) begin
                        nxt_oe = 1'b1;
                        nxt_rw = sh_ff[0];
                        nxt_state = ST_ADDR_ACK;
                     end else begin
                        // Not ours: keep off the bus until the next START
                        nxt_state = ST_IDLE;
                     end
                  end else if (state_ff == ST_REG) begin
                     nxt_ptr = sh_ff[6:0];
                     nxt_oe = 1'b1;
                     nxt_state = ST_REG_ACK;
                  end else begin
                     i2cWr = 1'b1;
                     nxt_ptr = ptrInc;
                     nxt_oe = 1'b1;
                     nxt_state = ST_WDATA_ACK;
                  end
               end
            end
            ST_ADDR_ACK: begin
               if (sclFall) begin
                  if (rw_ff) begin
                     nxt_sh = shiftOut(rdCur);
                     nxt_oe = ~rdCur[7];
                     nxt_ptr = ptrInc;
                     nxt_state = ST_RDATA;
                  end else begin
                     nxt_oe = 1'b0;
                     nxt_state = ST_REG;
                  end
               end
            end
            // Every later byte is data for the pointer
            ST_REG_ACK, ST_WDATA_ACK: begin
               if (sclFall) begin
                  nxt_oe = 1'b0;
                  nxt_state = ST_WDATA;
               end
            end
            ST_RDATA: begin
               if (sclRise) begin
                  nxt_bitCnt = cntInc;
               end else if (sclFall) begin
                  if (byteDone) begin
                     nxt_bitCnt = 4'h0;
                     nxt_oe = 1'b0;
                     nxt_state = ST_RDATA_ACK;
                  end else begin
                     nxt_oe = ~sh_ff[7];
                     nxt_sh = shiftOut(sh_ff);
                  end
               end
            end
            ST_RDATA_ACK: begin
               // Master acknowledge is taken while SCL is high, acted on at the fall
               if (sclRise) begin
                  nxt_ackd = ~sdaS_ff;
               end else if (sclFall) begin
                  if (ackd_ff) begin
                     nxt_sh = shiftOut(rdCur);
                     nxt_oe = ~rdCur[7];
                     nxt_ptr = ptrInc;
                     nxt_state = ST_RDATA;
                  end else begin
                     nxt_state = ST_IDLE;
                  end
               end
            end
         endcase
      end
   end

   // Any reset leaves SDA released
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         state_ff <= ST_IDLE;
         bitCnt_ff <= 4'h0;
         sh_ff <= 8'h00;
         ptr_ff <= 7'h00;
         rw_ff <= 1'b0;
         ackd_ff <= 1'b0;
         sdaOe_ff <= 1'b0;
      end else begin
         state_ff <= nxt_state;
         bitCnt_ff <= nxt_bitCnt;
         sh_ff <= nxt_sh;
         ptr_ff <= nxt_ptr;
         rw_ff <= nxt_rw;
         ackd_ff <= nxt_ackd;
         sdaOe_ff <= nxt_oe;
      end
   end

   // Register array, one write port shared by both protocols
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         for (int i = 0; i < `CCRP_NREGS; i++) begin
            regMem_ff[i] <= `CCRP_REG_RST;
         end
      end else if (memWe) begin
         regMem_ff[memWr.addr] <= memWr.data;
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         regWr_ff <= '0;
         regWrStb_ff <= 1'b0;
         gcEnable_ff <= 1'b0;
         rdByte_ff <= 8'h00;
         sdaOut_ff <= 1'b0;
      end else begin
         regWr_ff <= memWr;
         regWrStb_ff <= memWe;
         gcEnable_ff <= regMem_ff[`CCRP_GC_REG][`CCRP_GC_BIT];
         // Open drain: the pin is only ever pulled low
         sdaOut_ff <= 1'b0;
         // Address is held steady by the link until the next frame
         if (rdReq) begin
            rdByte_ff <= regMem_ff[spiAddr_ff];
         end
      end
   end

   // Link domain: sample on falling sclk, drive on rising sclk
   always_ff @(negedge sclk or posedge fsRst) begin
      if (fsRst) begin
         spiCnt_ff <= 5'h00;
         spiSh_ff <= 7'h00;
      end else if (!spiFull) begin
         // Count stops at sixteen: bits of an over-long frame are ignored
         spiCnt_ff <= spiCntInc;
         spiSh_ff <= {spiSh_ff[5:0], sdaMosiPin};
      end
   end

   // Handoff words survive the frame end so the system side can finish
   always_ff @(negedge sclk or posedge sys_rst) begin
      if (sys_rst) begin
         spiAddr_ff <= 7'h00;
         spiRw_ff <= 1'b0;
         spiData_ff <= 8'h00;
         rdTgl_ff <= 1'b0;
         wrTgl_ff <= 1'b0;
      end else if (!fsRst) begin
         if (spiCnt_ff == `CCRP_ADDR_LAST) begin
            spiAddr_ff <= {spiSh_ff[5:0], sdaMosiPin};
            rdTgl_ff <= ~rdTgl_ff;
         end
         if (spiCnt_ff == `CCRP_RW_LAST) begin
            spiRw_ff <= sdaMosiPin;
         end
         // Only a complete write byte is handed over
         if (spiCnt_ff == `CCRP_DATA_LAST && spiRw_ff != `CCRP_RW_READ) begin
            spiData_ff <= {spiSh_ff, sdaMosiPin};
            wrTgl_ff <= ~wrTgl_ff;
         end
      end
   end

   // Read byte must be fetched between falling edge 7 and rising edge 9
   always_ff @(posedge sclk or posedge fsRst) begin
      if (fsRst) begin
         misoSh_ff <= 8'h00;
         misoOut_ff <= 1'b0;
         misoOe_ff <= 1'b0;
      end else begin
         misoOe_ff <= 1'b1;
         if (cmdDone && spiRw_ff == `CCRP_RW_READ) begin
            misoOut_ff <= rdByte_ff[7];
            misoSh_ff <= shiftOut(rdByte_ff);
         end else begin
            misoOut_ff <= misoSh_ff[7];
            misoSh_ff <= shiftOut(misoSh_ff);
         end
      end
   end

   // Every output comes straight from a flip-flop
   assign sdaOut = sdaOut_ff;
   assign sdaOe = sdaOe_ff;
   assign misoOut = misoOut_ff;
   assign misoOe = misoOe_ff;
   assign regWr = regWr_ff;
   assign regWrStb = regWrStb_ff;
   assign gcEnable = gcEnable_ff;
endmodule

/* File: verification/ccrp_ctrl_port_props.sv */
// Purpose: Port-level checks of the codec register control port
// Assumes: One clock domain seen at clk; sclk sampled as plain data
// Notes: Bound into every instance of the port
`timescale 1ns/100ps
module ccrp_ctrl_port_props
   import ccrp_pkg::*;
(
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic spiSelPin,
   input wire logic sclFsPin,
   input wire logic sdaMosiPin,
   input wire logic sclk,
   input wire logic sdaOut,
   input wire logic sdaOe,
   input wire logic misoOut,
   input wire logic misoOe,
   input ccrp_wr_s regWr,
   input wire logic regWrStb,
   input wire logic gcEnable
);
   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);
   a_miso_idle_sel: assert property (spiSelPin && sclFsPin |-> !misoOe)
      else $error("MISO driven outside a frame");
   a_i2c_no_miso: assert property (!spiSelPin |-> !misoOe)
      else $error("MISO driven in I2C mode");
   a_spi_no_sda: assert property (spiSelPin && $past(spiSelPin, 4) |-> !sdaOe)
      else $error("SDA pulled in SPI mode");
   a_stb_single: assert property (regWrStb |=> !regWrStb)
      else $error("Write strobe longer than one cycle");
   a_gc_follow: assert property (regWrStb && regWr.addr == 7'h22 |-> ##3 gcEnable == $past(regWr.data[5], 3))
      else $error("General call enable not following its bit");
   a_gc_cause: assert property ($changed(gcEnable) |-> $past(regWrStb) || $past(regWrStb, 2))
      else $error("General call enable moved without a write");
   a_miso_edge: assert property (misoOe && $changed(misoOut) |-> sclk)
      else $error("MISO changed off a rising sclk edge");
   a_oe_first_edge: assert property ($rose(misoOe) |-> sclk && !sclFsPin)
      else $error("MISO enabled without the first sclk edge");
endmodule
bind ccrp_ctrl_port ccrp_ctrl_port_props ccrp_ctrl_port_props_inst (.clk(clk), .sys_rst(sys_rst),
   .spiSelPin(spiSelPin), .sclFsPin(sclFsPin), .sdaMosiPin(sdaMosiPin), .sclk(sclk), .sdaOut(sdaOut),
   .sdaOe(sdaOe), .misoOut(misoOut), .misoOe(misoOe), .regWr(regWr), .regWrStb(regWrStb), .gcEnable(gcEnable));

/* File: verification/ccrp_host_model.sv */
// Purpose: SPI master standing in for the host processor
// Assumes: 30 ns sclk, mode CPOL 0 CPHA 1
// Notes: Frame length is a task argument so frames can be cut short
`timescale 1ns/100ps
module ccrp_host_model (
   output logic sclk,
   output logic selN,
   output logic mosi,
   input wire logic miso
);
   initial begin
      sclk <= 1'b0;
      selN <= 1'b1;
      mosi <= 1'b0;
   end
   task automatic frame(input logic [23:0] tx, input int n, output logic [7:0] rx);
      int i;
      rx = 8'h00;
      #7.3 selN = 1'b0;
      #20;
      for (i = 0; i < n; i++) begin
         sclk = 1'b1;
         mosi = tx[23 - i];
         #15 sclk = 1'b0;
         if (i > 7 && i < 16) rx[15 - i] = miso;
         #15;
      end
      selN = 1'b1;
      mosi = ~mosi;
   endtask
endmodule

/* File: verification/ccrp_ctrl_port_tb.sv */
// Purpose: Self-checking bench of the codec register control port
// Assumes: SPI host model drives the link; bench drives I2C
// Notes: Register contents mirrored in mem from the writes made through spiWr
`timescale 1ns/100ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin err_count++; \
   $display("BAD t=%0t got=%h exp=%h", $time, a, b); end end
module ccrp_ctrl_port_tb
   import ccrp_pkg::*;
;
   logic clk = 1'b0, sys_rst, spiSel = 1'b1, scl = 1'b1, sdaM = 1'b1, k, sdaOut, sdaOe, misoOut, misoOe;
   logic regWrStb, gcEnable;
   logic [7:0] r, d1;
   logic [7:0] mem [128];
   logic [6:0] adr [8];
   wire sclk, selN, mosi;
   wire sdaW = sdaM & ((sdaOe === 1'b1) ? sdaOut : 1'b1);
   int err_count = 0, checked = 0, i;
   ccrp_wr_s regWr, w;
   ccrp_wr_s wq [$];
   initial forever #2 clk = ~clk;
   ccrp_host_model ccrp_host_model_inst (.sclk(sclk), .selN(selN), .mosi(mosi),
      .miso(misoOe === 1'b1 ? misoOut : clk));
   ccrp_ctrl_port ccrp_ctrl_port_inst (.clk(clk), .sys_rst(sys_rst), .spiSelPin(spiSel),
      .sclFsPin(spiSel ? selN : scl), .sdaMosiPin(spiSel ? mosi : sdaW), .sclk(sclk), .sdaOut(sdaOut),
      .sdaOe(sdaOe), .misoOut(misoOut), .misoOe(misoOe), .regWr(regWr), .regWrStb(regWrStb), .gcEnable(gcEnable));
   always @(posedge clk) if (regWrStb === 1'b1) wq.push_back(regWr);
   function automatic logic [7:0] cmd(input logic [6:0] a, input logic rd);
      return {a, rd};
   endfunction
   task results;
      $display("checked=%0d err_count=%0d", checked, err_count);
      if (err_count == 0 && checked > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   task expStb(input int n, input logic [14:0] e);
      repeat (10) @(posedge clk);
      `CHK(wq.size(), n)
      if (n > 0 && wq.size() > 0) begin
         w = wq.pop_front();
         `CHK(w, e)
      end
      wq.delete();
   endtask
   task spiWr(input logic [6:0] a, input logic [7:0] d);
      ccrp_host_model_inst.frame({cmd(a, 1'b0), d, 8'h00}, 16, r);
      mem[a] = d;
      expStb(1, {a, d});
   endtask
   task spiRd(input logic [6:0] a);
      ccrp_host_model_inst.frame({cmd(a, 1'b1), 16'h0000}, 16, r);
      `CHK(r, mem[a])
      expStb(0, 15'h0000);
   endtask
   task q;
      repeat (8) @(posedge clk);
   endtask
   task iBit(input logic b, output logic o);
      sdaM <= b;
      q;
      scl <= 1'b1;
      q;
      o = sdaW;
      q;
      scl <= 1'b0;
      q;
   endtask
   task iStart;
      sdaM <= 1'b1;
      q;
      scl <= 1'b1;
      q;
      sdaM <= 1'b0;
      q;
      scl <= 1'b0;
      q;
   endtask
   task iStop;
      sdaM <= 1'b0;
      q;
      scl <= 1'b1;
      q;
      sdaM <= 1'b1;
      q;
   endtask
   task iByte(input logic [7:0] b, input logic a);
      int j;
      for (j = 7; j >= 0; j--) iBit(b[j], r[j]);
      iBit(a, k);
   endtask
   initial begin
      #300000;
      err_count++;
      results;
   end
   initial begin
      sys_rst <= 1'b1;
      void'($urandom(9778));
      for (i = 0; i < 128; i++) mem[i] = 8'h00;
      repeat (10) @(posedge clk);
      sys_rst <= 1'b0;
      repeat (6) @(posedge clk);
      spiRd(7'h00);
      for (i = 0; i < 8; i++) begin
         adr[i] = (i == 0) ? 7'h7f : (i == 1) ? 7'h00 : 7'($urandom_range(126, 1));
         spiWr(adr[i], 8'($urandom));
      end
      spiWr(7'h22, 8'h00);
      for (i = 0; i < 8; i++) spiRd(adr[i]);
      ccrp_host_model_inst.frame({cmd(7'h05, 1'b0), 8'ha5, 8'h00}, 12, r);
      expStb(0, 15'h0000);
      spiRd(7'h05);
      ccrp_host_model_inst.frame({cmd(7'h09, 1'b0), 8'h3c, 8'hff}, 24, r);
      expStb(1, {7'h09, 8'h3c});
      spiSel <= 1'b0;
      q;
      iStart;
      iByte(8'h00, 1'b1);
      `CHK(k, 1'b1)
      iStop;
      iStart;
      iByte(8'h32, 1'b1);
      `CHK(k, 1'b1)
      iStop;
      d1 = 8'($urandom);
      iStart;
      iByte(8'h30, 1'b1);
      `CHK(k, 1'b0)
      iByte(8'h21, 1'b1);
      iByte(d1, 1'b1);
      iByte(8'h20, 1'b1);
      `CHK(k, 1'b0)
      iStop;
      `CHK(wq.size(), 2)
      w = wq.pop_front();
      `CHK(w, {7'h21, d1})
      w = wq.pop_front();
      `CHK(w, {7'h22, 8'h20})
      `CHK(gcEnable, 1'b1)
      iStart;
      iByte(8'h00, 1'b1);
      `CHK(k, 1'b0)
      iStop;
      iStart;
      iByte(8'h30, 1'b1);
      iByte(8'h21, 1'b1);
      iStart;
      iByte(8'h31, 1'b1);
      iByte(8'hff, 1'b0);
      `CHK(r, d1)
      iByte(8'hff, 1'b1);
      `CHK(r, 8'h20)
      iStop;
      results;
   end
endmodule
